/* File: hdl/ssp_pkg.sv */
// constants shared by the serial shift port files
package ssp_pkg;

	// peripheral register numbers (pointer value)
	localparam logic [3:0] SSP_CTRL_ADDR = 4'h1;
	localparam logic [3:0] SSP_BUF_ADDR = 4'h2;
	localparam logic [3:0] SSP_TPC_ADDR = 4'h3;

	// control register field positions
	localparam int SSP_CTRL_START_BIT = 0;
	localparam int SSP_CTRL_EXT_BIT = 1;
	localparam int SSP_CTRL_DIR_BIT = 3;
	// prescaler halt field of the timer/prescaler control register
	localparam int SSP_TPC_HALT_BIT = 2;

	// reset values
	localparam logic SSP_EXT_RST = 1'b0;
	localparam logic SSP_DIR_RST = 1'b0;
	localparam logic SSP_END_RST = 1'b0;
	localparam logic SSP_HALT_RST = 1'b0;
	localparam logic [7:0] SSP_BUF_RST = 8'h00;
	localparam logic SSP_SCK_IDLE = 1'b1;

	// timing: clk is the oscillator, one instruction is six oscillator periods
	localparam int SSP_CLK_NS = 8;
	localparam int SSP_OSC_PER_INSTR = 6;
	localparam int SSP_INSTR_NS = SSP_OSC_PER_INSTR * SSP_CLK_NS;
	// external master waits two instruction periods after start
	localparam int SSP_ARM_INSTR = 2;
	localparam int SSP_ARM_NS = SSP_ARM_INSTR * SSP_INSTR_NS;
	localparam int SSP_ARM_CYCLES = (SSP_ARM_NS + SSP_CLK_NS - 1) / SSP_CLK_NS;
	// bits per byte transfer
	localparam int SSP_BITS = 8;

	typedef enum logic [2:0] {
		SSP_IDLE = 3'b001,
		SSP_ARMED = 3'b010,
		SSP_RUN = 3'b100
	} ssp_state_t;

endpackage

/* File: hdl/ssp_prescale.sv */
// shared prescaler giving half-period ticks of the internal shift clock
module ssp_prescale #(
	parameter int TAP_LOG2 = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic halt,
	output logic tick
);
	localparam int HALF = (TAP_LOG2 > 1) ? (1 << (TAP_LOG2 - 1)) : 1;
	localparam logic [11:0] HALF_LAST = 12'(HALF - 1);
	localparam logic [3:0] INSTR_LAST = 4'(ssp_pkg::SSP_OSC_PER_INSTR - 1);

	logic [3:0] osc_cnt_r;
	logic [3:0] osc_cnt_nxt;
	logic [11:0] div_cnt_r;
	logic [11:0] div_cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		osc_cnt_nxt = osc_cnt_r;
		div_cnt_nxt = div_cnt_r;
		tick_nxt = 1'b0;
		if (halt) begin
			// a halted prescaler restarts from zero
			osc_cnt_nxt = 4'h0;
			div_cnt_nxt = 12'h000;
		end else if (osc_cnt_r == INSTR_LAST) begin
			// instruction rate then a power-of-two division
			osc_cnt_nxt = 4'h0;
			if (div_cnt_r == HALF_LAST) begin
				div_cnt_nxt = 12'h000;
				tick_nxt = 1'b1;
			end else begin
				div_cnt_nxt = div_cnt_r + 12'h001;
			end
		end else begin
			osc_cnt_nxt = osc_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osc_cnt_r <= 4'h0;
			div_cnt_r <= 12'h000;
			tick_r <= 1'b0;
		end else if (ce) begin
			osc_cnt_r <= osc_cnt_nxt;
			div_cnt_r <= div_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule // ssp_prescale

/* File: hdl/ssp_fifo.sv */
// small fifo holding received bytes, registered read data
module ssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] wp_nxt;
	logic [AW-1:0] rp_r;
	logic [AW-1:0] rp_nxt;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic [WIDTH-1:0] dout_r;
	logic [WIDTH-1:0] dout_nxt;
	logic dval_r;
	logic dval_nxt;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == LAST) ? '0 : p + AW'(1);
	endfunction

	always_comb begin
		push = in_valid && (cnt_r != FULL_CNT);
		pop = (cnt_r != '0) && (!dval_r || out_ready);
		wp_nxt = push ? ptr_inc(wp_r) : wp_r;
		rp_nxt = pop ? ptr_inc(rp_r) : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + (AW + 1)'(1);
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - (AW + 1)'(1);
		end
		dout_nxt = pop ? mem_r[rp_r] : dout_r;
		dval_nxt = pop ? 1'b1 : (dval_r && !out_ready);
	end

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			dout_r <= '0;
			dval_r <= 1'b0;
		end else if (ce) begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			dout_r <= dout_nxt;
			dval_r <= dval_nxt;
		end
	end

	assign in_ready = (cnt_r != FULL_CNT);
	assign out_data = dout_r;
	assign out_valid = dval_r;
endmodule // ssp_fifo

/* File: hdl/ssp_port.sv */
// eight-bit serial shift port with nibble register access
// How it works
// - writing start bit begins one byte
// - external clock: stays armed for the arm window, then runs on pin edges
// - 8-bit shifter, 3-bit counter, control register
// - preloaded byte goes out on the pins
// - bit 3 sets bidirectional pin direction
// - bit order fixed by build parameter
// - 3-wire: out on fall, sample on rise
// - 2-wire: bidir pin out fall, in rise
// - internal source drives clock pin out
// - eighth clock ends byte, raises interrupt
// - internal clock is instruction rate over power-of-two
// - prescaler halt bit stops internal transfers
// - control or buffer writes mid-transfer reset counter, abort transfer
// - external first edge two instructions after start
// - end flag set at byte end, cleared by start
// - all-zero control selects internal clock, receive
// - buffer accessed in nibbles chosen by pointer lsb
// - control read returns end flag in bit 0
module ssp_port #(
	parameter bit MSB_FIRST = 1'b1,
	parameter int TAP_LOG2 = 1,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [3:0] cpu_addr,
	input wire logic cpu_ylsb,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [3:0] cpu_wdata,
	output logic [3:0] cpu_rdata,
	output logic serial_irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic serial_out_pin,
	input wire logic serial_bidir_pin_in,
	output logic serial_bidir_pin_out,
	output logic serial_bidir_pin_oe,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready
);
	localparam logic [7:0] ARM_LOAD = 8'(ssp_pkg::SSP_ARM_CYCLES);
	localparam logic [2:0] CNT_LAST = 3'(ssp_pkg::SSP_BITS - 1);

	ssp_pkg::ssp_state_t state_r;
	ssp_pkg::ssp_state_t state_nxt;
	logic [7:0] sr_r;
	logic [7:0] sr_nxt;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [7:0] arm_r;
	logic [7:0] arm_nxt;
	logic ext_r;
	logic ext_nxt;
	logic dir_r;
	logic dir_nxt;
	logic end_r;
	logic end_nxt;
	logic halt_r;
	logic halt_nxt;
	logic sck_r;
	logic sck_nxt;
	logic sck_oe_r;
	logic sck_oe_nxt;
	logic sck_prev_r;
	logic out_bit_r;
	logic out_bit_nxt;
	logic irq_r;
	logic irq_nxt;
	logic push_r;
	logic push_nxt;
	logic [7:0] push_data_r;
	logic [7:0] push_data_nxt;
	logic [3:0] rdata_r;
	logic [3:0] rdata_nxt;
	logic tick;
	logic fifo_ready;
	logic fall;
	logic rise;
	logic wr_ctrl;
	logic wr_buf;
	logic wr_tpc;
	logic start_wr;

	function automatic logic lead_bit(input logic [7:0] v);
		lead_bit = MSB_FIRST ? v[7] : v[0];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
		shift_in = MSB_FIRST ? {v[6:0], b} : {b, v[7:1]};
	endfunction

	// register select shared by the write decode
	function automatic logic reg_hit(input logic s, input logic [3:0] a, input logic [3:0] r);
		reg_hit = s && (a == r);
	endfunction

	ssp_prescale #(
		.TAP_LOG2(TAP_LOG2)
	) u_prescale (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.halt(halt_r),
		.tick(tick)
	);

	ssp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_data(push_data_r),
		.in_valid(push_r),
		.in_ready(fifo_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	always_comb begin
		wr_ctrl = reg_hit(cpu_wr, cpu_addr, ssp_pkg::SSP_CTRL_ADDR);
		wr_buf = reg_hit(cpu_wr, cpu_addr, ssp_pkg::SSP_BUF_ADDR);
		wr_tpc = reg_hit(cpu_wr, cpu_addr, ssp_pkg::SSP_TPC_ADDR);
		start_wr = wr_ctrl && cpu_wdata[ssp_pkg::SSP_CTRL_START_BIT];
		// edges: internal from the prescaler, external from the clock pin
		if (ext_r) begin
			fall = sck_prev_r && !sck_in;
			rise = !sck_prev_r && sck_in;
		end else begin
			fall = tick && sck_r;
			rise = tick && !sck_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		sr_nxt = sr_r;
		cnt_nxt = cnt_r;
		arm_nxt = arm_r;
		ext_nxt = ext_r;
		dir_nxt = dir_r;
		end_nxt = end_r;
		halt_nxt = halt_r;
		sck_nxt = sck_r;
		out_bit_nxt = out_bit_r;
		irq_nxt = 1'b0;
		push_nxt = 1'b0;
		push_data_nxt = push_data_r;
		unique case (state_r)
			ssp_pkg::SSP_IDLE: begin
				sck_nxt = ssp_pkg::SSP_SCK_IDLE;
				out_bit_nxt = lead_bit(sr_r);
			end
			ssp_pkg::SSP_ARMED: begin
				sck_nxt = ssp_pkg::SSP_SCK_IDLE;
				out_bit_nxt = lead_bit(sr_r);
				// edges during the arm window are not seen
				if (arm_r != 8'h00) begin
					arm_nxt = arm_r - 8'h01;
				end else if (fifo_ready && !push_r) begin
					state_nxt = ssp_pkg::SSP_RUN;
				end
			end
			ssp_pkg::SSP_RUN: begin
				if (!ext_r && tick) begin
					sck_nxt = !sck_r;
				end
				if (fall) begin
					out_bit_nxt = lead_bit(sr_r);
				end
				if (rise) begin
					sr_nxt = shift_in(sr_r, serial_bidir_pin_in);
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == CNT_LAST) begin
						// eighth clock closes the byte
						state_nxt = ssp_pkg::SSP_IDLE;
						end_nxt = 1'b1;
						irq_nxt = 1'b1;
						push_nxt = 1'b1;
						push_data_nxt = shift_in(sr_r, serial_bidir_pin_in);
					end
				end
			end
			default: begin
				state_nxt = ssp_pkg::SSP_IDLE;
			end
		endcase
		// prescaler halt leaves internal transfers frozen
		if (wr_tpc) begin
			halt_nxt = cpu_wdata[ssp_pkg::SSP_TPC_HALT_BIT];
		end
		if (wr_ctrl || wr_buf) begin
			// a control or buffer write aborts a transfer in flight
			state_nxt = ssp_pkg::SSP_IDLE;
			cnt_nxt = 3'h0;
			sck_nxt = ssp_pkg::SSP_SCK_IDLE;
			irq_nxt = 1'b0;
			push_nxt = 1'b0;
			end_nxt = end_r;
			sr_nxt = sr_r;
		end
		if (wr_buf) begin
			// nibble picked by the pointer lsb
			if (cpu_ylsb) begin
				sr_nxt = {cpu_wdata, sr_r[3:0]};
			end else begin
				sr_nxt = {sr_r[7:4], cpu_wdata};
			end
		end
		if (wr_ctrl) begin
			ext_nxt = cpu_wdata[ssp_pkg::SSP_CTRL_EXT_BIT];
			dir_nxt = cpu_wdata[ssp_pkg::SSP_CTRL_DIR_BIT];
			if (start_wr) begin
				state_nxt = ssp_pkg::SSP_ARMED;
				end_nxt = 1'b0;
				arm_nxt = cpu_wdata[ssp_pkg::SSP_CTRL_EXT_BIT] ? ARM_LOAD : 8'h00;
			end
		end
		sck_oe_nxt = !ext_nxt;
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (cpu_rd) begin
			unique case (cpu_addr)
				ssp_pkg::SSP_CTRL_ADDR: rdata_nxt = {dir_r, 1'b0, ext_r, end_r};
				ssp_pkg::SSP_BUF_ADDR: rdata_nxt = cpu_ylsb ? sr_r[7:4] : sr_r[3:0];
				ssp_pkg::SSP_TPC_ADDR: rdata_nxt = {1'b0, halt_r, 2'b00};
				default: rdata_nxt = 4'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ssp_pkg::SSP_IDLE;
			sr_r <= ssp_pkg::SSP_BUF_RST;
			cnt_r <= 3'h0;
			arm_r <= 8'h00;
			ext_r <= ssp_pkg::SSP_EXT_RST;
			dir_r <= ssp_pkg::SSP_DIR_RST;
			end_r <= ssp_pkg::SSP_END_RST;
			halt_r <= ssp_pkg::SSP_HALT_RST;
			sck_r <= ssp_pkg::SSP_SCK_IDLE;
			sck_oe_r <= 1'b1;
			out_bit_r <= 1'b0;
			irq_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= 8'h00;
		end else if (ce) begin
			state_r <= state_nxt;
			sr_r <= sr_nxt;
			cnt_r <= cnt_nxt;
			arm_r <= arm_nxt;
			ext_r <= ext_nxt;
			dir_r <= dir_nxt;
			end_r <= end_nxt;
			halt_r <= halt_nxt;
			sck_r <= sck_nxt;
			sck_oe_r <= sck_oe_nxt;
			out_bit_r <= out_bit_nxt;
			irq_r <= irq_nxt;
			push_r <= push_nxt;
			push_data_r <= push_data_nxt;
		end
	end

	// read nibble register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 4'h0;
		end else if (ce) begin
			rdata_r <= rdata_nxt;
		end
	end

	// clock pin history for edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev_r <= ssp_pkg::SSP_SCK_IDLE;
		end else if (ce) begin
			sck_prev_r <= sck_in;
		end
	end

	assign cpu_rdata = rdata_r;
	assign serial_irq = irq_r;
	assign sck_out = sck_r;
	assign sck_oe = sck_oe_r;
	assign serial_out_pin = out_bit_r;
	assign serial_bidir_pin_out = out_bit_r;
	assign serial_bidir_pin_oe = dir_r;
endmodule // ssp_port

/* File: tb/ssp_port_asserts.sv */
// assertion checker for the serial shift port
module ssp_port_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [3:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [3:0] cpu_wdata,
	input wire logic [3:0] cpu_rdata,
	input wire logic serial_irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic serial_out_pin,
	input wire logic serial_bidir_pin_oe
);
	logic cw;
	logic halt_r;
	logic halt_nxt;
	logic busy_r;
	logic busy_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	assign cw = ce && cpu_wr;
	always_comb begin
		halt_nxt = halt_r;
		busy_nxt = busy_r;
		if (cw && cpu_addr == 4'h3) begin
			halt_nxt = cpu_wdata[2];
		end
		// a byte is in flight from a start write to its interrupt or an abort
		if (cw && cpu_addr == 4'h1) begin
			busy_nxt = cpu_wdata[0];
		end else if (cw && cpu_addr == 4'h2) begin
			busy_nxt = 1'b0;
		end else if (serial_irq) begin
			busy_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		halt_r <= sys_rst ? 1'b0 : halt_nxt;
		busy_r <= sys_rst ? 1'b0 : busy_nxt;
	end
	AST_DIR_OE: assert property (
		cw && cpu_addr == 4'h1 |-> ##2 serial_bidir_pin_oe == $past(cpu_wdata[3], 2))
		else $error("bad pin direction");
	AST_SRC_OE: assert property (
		cw && cpu_addr == 4'h1 |-> ##2 sck_oe == !$past(cpu_wdata[1], 2))
		else $error("bad clock source");
	AST_SCK_HALF: assert property (
		sck_oe && $rose(sck_out) |=> $stable(sck_out) [*5]) else $error("short clock half");
	AST_HALT: assert property (
		sck_oe && halt_r && $past(halt_r) && !cw |=> $stable(sck_out))
		else $error("clock runs while halted");
	AST_OUT_FALL: assert property (
		busy_r && sck_oe && $changed(serial_out_pin) && !cw && !$past(cw) && !$past(cw, 2)
		|-> !sck_out)
		else $error("data moved off falling edge");
	AST_IRQ_ONE: assert property (
		serial_irq |=> !serial_irq) else $error("interrupt too long");
	AST_IRQ_HIGH: assert property (
		serial_irq && sck_oe |-> sck_out && !$past(sck_out)) else $error("interrupt mid bit");
	AST_START_CLR: assert property (
		cw && cpu_addr == 4'h1 && cpu_wdata[0] ##2 ce && cpu_rd && cpu_addr == 4'h1
		|=> !cpu_rdata[0]) else $error("end flag not cleared");
endmodule // ssp_port_asserts

bind ssp_port ssp_port_asserts ssp_port_asserts_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
	.cpu_rdata(cpu_rdata), .serial_irq(serial_irq), .sck_out(sck_out), .sck_oe(sck_oe),
	.serial_out_pin(serial_out_pin), .serial_bidir_pin_oe(serial_bidir_pin_oe));

/* File: tb/ssp_peer.sv */
// model of the external serial device
module ssp_peer (
	input wire logic clk,
	input wire logic sck_line,
	input wire logic din,
	output logic sck_drv,
	output logic dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_r = 8'h00;
	logic [7:0] rx_r = 8'h00;
	initial begin
		sck_drv = 1'b1;
		dout = 1'b0;
	end
	// inverted copy of the byte follows it as filler
	always @(negedge sck_line) begin
		dout <= tx_r[7];
		tx_r <= {tx_r[6:0], ~tx_r[7]};
	end
	always @(posedge sck_line) begin
		rx_r <= {rx_r[6:0], din};
	end
	// 125 cycle halves, idle high, first edge well after start
	task automatic clock_byte(input int n);
		repeat (n) begin
			repeat (125) @(posedge clk);
			sck_drv <= 1'b0;
			repeat (125) @(posedge clk);
			sck_drv <= 1'b1;
		end
	endtask
endmodule // ssp_peer

/* File: tb/ssp_port_tb.sv */
// testbench for the serial shift port
module ssp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [3:0] cfg;
		logic [7:0] tx;
		logic [7:0] ptx;
		logic [7:0] exp;
	} ssp_row_t;
	logic clk;
	logic sys_rst;
	logic [3:0] cpu_addr;
	logic cpu_ylsb;
	logic cpu_wr;
	logic cpu_rd;
	logic [3:0] cpu_wdata;
	logic [3:0] cpu_rdata;
	logic serial_irq;
	logic sck_out;
	logic sck_oe;
	logic serial_out_pin;
	logic bidir_out;
	logic bidir_oe;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ready;
	logic sck_drv;
	logic peer_dout;
	wire sck_line = sck_oe ? sck_out : sck_drv;
	wire bidir_line = bidir_oe ? bidir_out : peer_dout;
	wire peer_din = bidir_oe ? bidir_line : serial_out_pin;
	int failures = 0;
	int cmp_count = 0;
	int irq_n = 0;
	int cyc = 0;
	logic [7:0] q[$];
	ssp_row_t rows [4] = '{'{4'h0, 8'hA5, 8'h3C, 8'h3C}, '{4'h8, 8'h96, 8'h00, 8'h96},
		'{4'h2, 8'h81, 8'hE7, 8'hE7}, '{4'hA, 8'h5A, 8'hFF, 8'h5A}};
	ssp_port #(.MSB_FIRST(1'b1), .TAP_LOG2(1), .FIFO_DEPTH(8)) ssp_port_inst (
		.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .cpu_addr(cpu_addr), .cpu_ylsb(cpu_ylsb),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.serial_irq(serial_irq), .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe),
		.serial_out_pin(serial_out_pin), .serial_bidir_pin_in(bidir_line),
		.serial_bidir_pin_out(bidir_out), .serial_bidir_pin_oe(bidir_oe),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
	ssp_peer ssp_peer_inst (.clk(clk), .sck_line(sck_line), .din(peer_din),
		.sck_drv(sck_drv), .dout(peer_dout));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (serial_irq === 1'b1) irq_n++;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic y, input logic [3:0] d);
		@(posedge clk);
		cpu_addr <= a;
		cpu_ylsb <= y;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge clk);
		cpu_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic y, input logic [3:0] e);
		@(posedge clk);
		cpu_addr <= a;
		cpu_ylsb <= y;
		cpu_rd <= 1'b1;
		@(posedge clk);
		cpu_rd <= 1'b0;
		#1;
		chk({4'h0, cpu_rdata}, {4'h0, e});
	endtask
	task automatic wait_irq(input int n0);
		for (int i = 0; i < 3000 && irq_n == n0; i++) @(posedge clk);
		#1;
		chk(8'(irq_n - n0), 8'h01);
	endtask
	task automatic xfer(input ssp_row_t r, input logic halt);
		int n0;
		n0 = irq_n;
		wr(4'h1, 1'b0, r.cfg);
		wr(4'h2, 1'b0, r.tx[3:0]);
		wr(4'h2, 1'b1, r.tx[7:4]);
		ssp_peer_inst.tx_r = r.ptx;
		if (halt) wr(4'h3, 1'b0, 4'h4);
		wr(4'h1, 1'b0, r.cfg | 4'h1);
		rd(4'h1, 1'b0, r.cfg & 4'hA);
		if (halt) begin
			repeat (200) @(posedge clk);
			chk(8'(irq_n - n0), 8'h00);
			wr(4'h3, 1'b0, 4'h0);
		end
		if (r.cfg[1]) ssp_peer_inst.clock_byte(8);
		wait_irq(n0);
		chk(ssp_peer_inst.rx_r, r.tx);
		rd(4'h2, 1'b0, r.exp[3:0]);
		rd(4'h2, 1'b1, r.exp[7:4]);
		rd(4'h1, 1'b0, (r.cfg & 4'hA) | 4'h1);
		q.push_back(r.exp);
	endtask
	initial begin
		int n;
		sys_rst = 1'b1;
		cpu_addr = 4'h0;
		cpu_ylsb = 1'b0;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_wdata = 4'h0;
		rx_ready = 1'b0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) xfer(rows[i], 1'b0);
		xfer(rows[0], 1'b1);
		repeat (4) xfer(rows[0], 1'b0);
		n = irq_n;
		wr(4'h1, 1'b0, 4'h1);
		repeat (200) @(posedge clk);
		chk(8'(irq_n - n), 8'h00);
		wr(4'h1, 1'b0, 4'h0);
		rd(4'h1, 1'b0, 4'h0);
		foreach (q[i]) begin
			for (n = 0; n < 50 && rx_valid !== 1'b1; n++) @(posedge clk);
			#1;
			chk(rx_data, q[i]);
			@(posedge clk);
			rx_ready <= 1'b1;
			@(posedge clk);
			rx_ready <= 1'b0;
			repeat (3) @(posedge clk);
		end
		chk({7'h00, rx_valid}, 8'h00);
		wr(4'h1, 1'b0, 4'hA);
		rd(4'h1, 1'b0, 4'hA);
		chk({6'h00, bidir_oe, sck_oe}, 8'h02);
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(4'h1, 1'b0, 4'h0);
		rd(4'h2, 1'b1, 4'h0);
		rd(4'h3, 1'b0, 4'h0);
		wr(4'h7, 1'b0, 4'hF);
		rd(4'h7, 1'b0, 4'h0);
		chk({6'h00, sck_oe, sck_out}, 8'h03);
		complete_run();
	end
endmodule // ssp_port_tb
